// ==== src/pcel_pkg.sv ====
// constants and carriers for the primary cache error latch
package pcel_pkg;
	// register byte offsets on the wishbone bus
	localparam logic [7:0] OFF_STATUS  = 8'h00;
	localparam logic [7:0] OFF_ERRADDR = 8'h04;
	localparam logic [7:0] OFF_TAGIDX  = 8'h08;
	localparam logic [7:0] OFF_TAGDATA = 8'h0c;
	localparam logic [7:0] OFF_IRQSTS  = 8'h10;
	localparam logic [7:0] OFF_IRQMASK = 8'h14;
	// status register fields
	localparam int ST_FORCE_HIT = 0;
	localparam int ST_TAG_EN    = 1;
	localparam int ST_FLUSH     = 2;
	localparam int ST_REFRESH   = 3;
	localparam int ST_INT       = 5;
	localparam int ST_SECOND    = 6;
	localparam int ST_FIRST     = 7;
	localparam int ST_DESC      = 8;
	localparam int DESC_W       = 5;
	// description field, bit positions within the 5-bit field
	localparam int D_TAGPAR  = 0;
	localparam int D_BUSPAR  = 1;
	localparam int D_DATAPAR = 2;
	localparam int D_BUSERR  = 3;
	localparam int D_BKHIT   = 4;
	// tag data register fields
	localparam int TG_VALID  = 31;
	localparam int TG_PARITY = 30;
	localparam int TG_ADDR_L = 11;
	localparam int TG_ADDR_W = 18;
	localparam int TG_W      = TG_ADDR_W + 2;
	// interrupt status and mask bits
	localparam int IRQ_INTCLS = 0;
	localparam int IRQ_FIRST  = 1;
	localparam int IRQ_SECOND = 2;
	localparam int IRQ_W      = 3;
	// reset values
	localparam logic [3:0]       CTRL_RST = 4'h0;
	localparam logic [DESC_W-1:0] DESC_RST = 5'h00;
	localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

	typedef enum logic [2:0] {
		PCEL_K_NONE,
		PCEL_K_TAGPAR,
		PCEL_K_DATAPAR,
		PCEL_K_BUSPAR,
		PCEL_K_BUSERR,
		PCEL_K_FPRES
	} pcel_kind_e;

	typedef enum logic [3:0] {
		PCEL_C_DREAD,
		PCEL_C_IREAD,
		PCEL_C_WRITE,
		PCEL_C_INVAL,
		PCEL_C_CLRWB,
		PCEL_C_EXTREG_RD,
		PCEL_C_VECTOR_RD,
		PCEL_C_RESULT,
		PCEL_C_OTHER
	} pcel_cmd_e;

	// one error report from the core, valid for one cycle
	typedef struct packed {
		logic        valid;
		pcel_kind_e  kind;
		pcel_cmd_e   cmd;
		logic        lw2;
		logic        pc_hit;
		logic        bc_hit;
		logic [31:0] addr;
	} pcel_err_s;

	typedef struct packed {
		logic              intr;
		logic              mchk;
		logic [DESC_W-1:0] desc;
	} pcel_cls_s;
endpackage

// ==== src/pcel_classify.sv ====
// error classifier: interrupt or machine check, and description bits
`timescale 1ns/1ps
module pcel_classify
	import pcel_pkg::*;
(
	// error report and cache mode
	input  wire pcel_err_s err_i,
	input  wire logic      force_hit_i,
	input  wire logic      tag_en_i,
	// classification
	output pcel_cls_s      cls_o
);
	logic dread;
	logic iread;

	assign dread = err_i.cmd == PCEL_C_DREAD;
	assign iread = err_i.cmd == PCEL_C_IREAD;

	always_comb begin
		cls_o = '0;
		if (err_i.valid) begin
			unique case (err_i.kind)
			PCEL_K_TAGPAR: begin
				// hit or miss alike, only on commands touching tags
				if (tag_en_i && !force_hit_i && (dread || iread ||
				    err_i.cmd == PCEL_C_WRITE ||
				    err_i.cmd == PCEL_C_INVAL)) begin
					cls_o.intr = 1'b1;
					cls_o.mchk = dread && err_i.pc_hit;
					cls_o.desc[D_TAGPAR] = 1'b1;
				end
			end
			PCEL_K_DATAPAR: begin
				// misses never report, data array is not writable
				if (err_i.pc_hit && !force_hit_i) begin
					cls_o.mchk = dread;
					cls_o.intr = iread;
					cls_o.desc[D_DATAPAR] = dread || iread;
				end
			end
			PCEL_K_BUSPAR: begin
				if (!err_i.pc_hit && (dread || iread)) begin
					cls_o.mchk = dread && !err_i.lw2;
					cls_o.intr = iread || err_i.lw2;
					cls_o.desc[D_BUSPAR] = 1'b1;
					cls_o.desc[D_BKHIT] = err_i.bc_hit;
				end
			end
			PCEL_K_BUSERR: begin
				// extreg and vector reads left to microcode
				cls_o.mchk = dread || err_i.cmd == PCEL_C_WRITE ||
				             err_i.cmd == PCEL_C_CLRWB;
				cls_o.intr = iread;
				cls_o.desc[D_BUSERR] = cls_o.mchk || cls_o.intr;
				cls_o.desc[D_BKHIT] = (cls_o.mchk || cls_o.intr) &&
				                      err_i.bc_hit;
			end
			PCEL_K_FPRES: begin
				cls_o.mchk = err_i.cmd == PCEL_C_RESULT;
			end
			default: cls_o = '0;
			endcase
		end
	end
endmodule

// ==== src/pcel_latch.sv ====
// primary cache error latch with wishbone register access
`timescale 1ns/1ps
// Function
// - no lock on extreg or vector bus errors
// - float result parity on a result command is always machine check
// - interrupt errors set status bit 5
// - interrupt keeps description if already locked
// - machine check sets first flag, latches all
// - second machine check sets second flag only
// - machine check overwrites interrupt description
// - data parity reported only on hit
// - tag parity reported on tag-touching commands with tag store on and no forced hit, bit 8
// - data read hit parity: bit 10, machine check
// - bus parity: flag, backup hit, longword class
// - tag writes over bus have no side effects
// - any error flag disables the cache
module pcel_latch
	import pcel_pkg::*;
#(
	parameter int TAG_DEPTH = 256
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// core error reports and tag lookup
	input  wire pcel_err_s   err_i,
	input  wire logic [$clog2(TAG_DEPTH)-1:0] tag_lkp_idx_i,
	output logic [31:0]      tag_entry_o,
	// cache control towards the core
	output logic             cache_enable_o,
	output logic             flush_o,
	output logic             refresh_enable_o,
	output logic             forced_hit_o,
	output logic             mchk_o,
	output logic             irq_o
);
	localparam int IDX_W = $clog2(TAG_DEPTH);

	generate
		if (TAG_DEPTH < 2 || (TAG_DEPTH & (TAG_DEPTH - 1)) != 0) begin : g_bad
			$error("TAG_DEPTH must be a power of two, at least 2");
		end
	endgenerate

	function automatic logic [31:0] pcel_merge(input logic [31:0] old_v,
	                                           input logic [31:0] new_v,
	                                           input logic [3:0]  sel);
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				old_v[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return old_v;
	endfunction

	logic                    force_hit_reg;
	logic                    tag_en_reg;
	logic                    refresh_reg;
	logic                    int_flag_reg;
	logic                    second_reg;
	logic                    first_reg;
	logic [DESC_W-1:0]       desc_reg;
	logic [31:0]             err_addr_reg;
	logic [IDX_W-1:0]        idx_reg;
	logic [IRQ_W-1:0]        irq_sts_reg;
	logic [IRQ_W-1:0]        irq_mask_reg;
	logic [TG_W-1:0]         tag_mem [TAG_DEPTH];
	logic [31:0]             status_v;
	logic [31:0]             rdata;
	logic [31:0]             tag_rd;
	logic [31:0]             wval;
	logic                    acc;
	logic                    wr_sts;
	logic                    wr_idx;
	logic                    wr_tag;
	logic                    wr_mask;
	logic                    rd_irq;
	logic [2:0]              flags;
	logic [IRQ_W-1:0]        irq_set;
	pcel_cls_s               cls;

	pcel_classify u_classify (
		.err_i       (err_i),
		.force_hit_i (force_hit_reg),
		.tag_en_i    (tag_en_reg),
		.cls_o       (cls)
	);

	// bus decode; writes and read clears act at the acked edge
	assign acc     = wb_cyc_i && wb_stb_i && wb_ack_o;
	assign wr_sts  = acc && wb_we_i && wb_adr_i == OFF_STATUS;
	assign wr_idx  = acc && wb_we_i && wb_adr_i == OFF_TAGIDX;
	assign wr_tag  = acc && wb_we_i && wb_adr_i == OFF_TAGDATA;
	assign wr_mask = acc && wb_we_i && wb_adr_i == OFF_IRQMASK;
	assign rd_irq  = acc && !wb_we_i && wb_adr_i == OFF_IRQSTS;
	assign flags   = {first_reg, second_reg, int_flag_reg};

	always_comb begin
		status_v = '0;
		status_v[ST_FORCE_HIT] = force_hit_reg;
		status_v[ST_TAG_EN]    = tag_en_reg;
		status_v[ST_REFRESH]   = refresh_reg;
		status_v[ST_INT]       = int_flag_reg;
		status_v[ST_SECOND]    = second_reg;
		status_v[ST_FIRST]     = first_reg;
		status_v[ST_DESC +: DESC_W] = desc_reg;
		tag_rd = '0;
		tag_rd[TG_VALID]  = tag_mem[idx_reg][TG_W-1];
		tag_rd[TG_PARITY] = tag_mem[idx_reg][TG_W-2];
		tag_rd[TG_ADDR_L +: TG_ADDR_W] = tag_mem[idx_reg][TG_ADDR_W-1:0];
		wval = '0;
		unique case (wb_adr_i)
		OFF_STATUS:  wval = status_v;
		OFF_TAGIDX:  wval = 32'(idx_reg);
		OFF_TAGDATA: wval = tag_rd;
		OFF_IRQMASK: wval = 32'(irq_mask_reg);
		default:     wval = '0;
		endcase
		wval = pcel_merge(wval, wb_dat_i, wb_sel_i);
		rdata = '0;
		unique case (wb_adr_i)
		OFF_STATUS:  rdata = status_v;
		OFF_ERRADDR: rdata = err_addr_reg;
		OFF_TAGIDX:  rdata = 32'(idx_reg);
		OFF_TAGDATA: rdata = tag_rd;
		OFF_IRQSTS:  rdata = 32'(irq_sts_reg);
		OFF_IRQMASK: rdata = 32'(irq_mask_reg);
		default:     rdata = '0;
		endcase
	end

	// one wait state, unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				wb_dat_o <= wb_we_i ? 32'h0000_0000 : rdata;
			end
		end
	end

	// mode bits; flush is a self-clearing pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{refresh_reg, flush_o, tag_en_reg, force_hit_reg} <= CTRL_RST;
		end else begin
			flush_o <= wr_sts && wval[ST_FLUSH];
			if (wr_sts) begin
				force_hit_reg <= wval[ST_FORCE_HIT];
				tag_en_reg    <= wval[ST_TAG_EN];
				refresh_reg   <= wval[ST_REFRESH];
			end
		end
	end

	// error flags; hardware sets win over a software write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_flag_reg <= 1'b0;
			second_reg   <= 1'b0;
			first_reg    <= 1'b0;
			desc_reg     <= DESC_RST;
			err_addr_reg <= '0;
		end else begin
			if (wr_sts) begin
				int_flag_reg <= wval[ST_INT];
				second_reg   <= wval[ST_SECOND];
				first_reg    <= wval[ST_FIRST];
				desc_reg     <= wval[ST_DESC +: DESC_W];
			end
			if (cls.intr) begin
				int_flag_reg <= 1'b1;
				if (!cls.mchk && !int_flag_reg && !first_reg) begin
					desc_reg <= cls.desc;
				end
			end
			if (cls.mchk) begin
				if (first_reg) begin
					second_reg <= 1'b1;
				end else begin
					first_reg    <= 1'b1;
					desc_reg     <= cls.desc;
					err_addr_reg <= err_i.addr;
				end
			end
		end
	end

	// tag store: plain bus writes, no error side effects
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idx_reg <= '0;
		end else if (wr_idx) begin
			idx_reg <= wval[IDX_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr_tag) begin
			tag_mem[idx_reg] <= {wval[TG_VALID], wval[TG_PARITY],
			                     wval[TG_ADDR_L +: TG_ADDR_W]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tag_entry_o <= '0;
		end else begin
			tag_entry_o <= '0;
			tag_entry_o[TG_VALID]  <= tag_mem[tag_lkp_idx_i][TG_W-1];
			tag_entry_o[TG_PARITY] <= tag_mem[tag_lkp_idx_i][TG_W-2];
			tag_entry_o[TG_ADDR_L +: TG_ADDR_W] <=
				tag_mem[tag_lkp_idx_i][TG_ADDR_W-1:0];
		end
	end

	// interrupt events; a read clears only the bits it returned
	assign irq_set[IRQ_INTCLS] = cls.intr;
	assign irq_set[IRQ_FIRST]  = cls.mchk && !first_reg;
	assign irq_set[IRQ_SECOND] = cls.mchk && first_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_sts_reg  <= '0;
			irq_mask_reg <= MASK_RST;
		end else begin
			irq_sts_reg <= (irq_sts_reg &
			               ~(rd_irq ? wb_dat_o[IRQ_W-1:0] : '0)) | irq_set;
			if (wr_mask) begin
				irq_mask_reg <= wval[IRQ_W-1:0];
			end
		end
	end

	// outputs lag their cause by one cycle to stay registered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o            <= 1'b0;
			mchk_o           <= 1'b0;
			cache_enable_o   <= 1'b0;
			refresh_enable_o <= 1'b0;
			forced_hit_o     <= 1'b0;
		end else begin
			irq_o            <= |(irq_sts_reg & irq_mask_reg);
			mchk_o           <= cls.mchk;
			cache_enable_o   <= tag_en_reg && !(|flags);
			refresh_enable_o <= refresh_reg;
			forced_hit_o     <= force_hit_reg;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_EXTREG_NO_LOCK: assert property (
		err_i.valid && err_i.kind == PCEL_K_BUSERR && !wr_sts &&
		(err_i.cmd == PCEL_C_EXTREG_RD || err_i.cmd == PCEL_C_VECTOR_RD)
		|=> $stable(flags) && $stable(desc_reg))
		else $error("bus error on extreg read locked status");
	AST_FPRES_MCHK: assert property (
		err_i.valid && err_i.kind == PCEL_K_FPRES &&
		err_i.cmd == PCEL_C_RESULT && !wr_sts
		|=> first_reg && mchk_o && int_flag_reg == $past(int_flag_reg))
		else $error("result parity not a machine check");
	AST_INT_SETS: assert property (
		cls.intr |=> int_flag_reg ##1 !cache_enable_o)
		else $error("interrupt flag not set");
	AST_INT_KEEPS: assert property (
		cls.intr && !cls.mchk && (int_flag_reg || first_reg) && !wr_sts
		|=> $stable(desc_reg))
		else $error("locked description overwritten");
	AST_MCHK_LATCH: assert property (
		cls.mchk && !first_reg
		|=> first_reg && desc_reg == $past(cls.desc) &&
		    err_addr_reg == $past(err_i.addr))
		else $error("first machine check not latched");
	AST_MCHK_SECOND: assert property (
		cls.mchk && first_reg && !wr_sts
		|=> second_reg && $stable(desc_reg) && $stable(err_addr_reg))
		else $error("second machine check changed latch");
	AST_MCHK_OVER_INT: assert property (
		cls.mchk && !first_reg && int_flag_reg
		|=> desc_reg == $past(cls.desc))
		else $error("machine check did not overwrite");
	AST_DATA_MISS: assert property (
		err_i.valid && err_i.kind == PCEL_K_DATAPAR && !err_i.pc_hit
		|-> !cls.intr && !cls.mchk)
		else $error("data parity reported on miss");
	AST_TAG_ANY: assert property (
		err_i.valid && err_i.kind == PCEL_K_TAGPAR && tag_en_reg &&
		!force_hit_reg && err_i.cmd == PCEL_C_WRITE && !(|flags)
		|=> int_flag_reg && desc_reg[D_TAGPAR])
		else $error("tag parity not reported");
	AST_DREAD_DATA: assert property (
		err_i.valid && err_i.kind == PCEL_K_DATAPAR && err_i.pc_hit &&
		!force_hit_reg && err_i.cmd == PCEL_C_DREAD && !(|flags) &&
		!wr_sts
		|=> first_reg && !int_flag_reg && desc_reg[D_DATAPAR])
		else $error("data read hit parity misreported");
	AST_BUS_LW2: assert property (
		err_i.valid && err_i.kind == PCEL_K_BUSPAR && !err_i.pc_hit &&
		err_i.cmd == PCEL_C_DREAD && err_i.lw2 && !(|flags) && !wr_sts
		|=> int_flag_reg && !first_reg &&
		    desc_reg == {$past(err_i.bc_hit), 4'h2})
		else $error("second longword parity misreported");
	AST_TAG_WRITE_QUIET: assert property (
		wr_tag && !cls.intr && !cls.mchk |=> $stable(flags))
		else $error("tag write touched flags");
	AST_DISABLE: assert property (
		|flags |=> !cache_enable_o)
		else $error("cache enabled with error flag");
	AST_HOLD: assert property (
		!wr_sts && !cls.intr && !cls.mchk
		|=> $stable(flags) && $stable(desc_reg))
		else $error("flags changed without write");
	AST_MCHK_OUT: assert property (
		cls.mchk |=> mchk_o)
		else $error("machine check pulse missing");
	AST_FPRES_NO_INT: assert property (
		err_i.valid && err_i.kind == PCEL_K_FPRES |-> !cls.intr)
		else $error("result parity raised an interrupt");
	AST_TAG_MCHK_INT: assert property (
		err_i.valid && err_i.kind == PCEL_K_TAGPAR && cls.mchk
		|-> cls.intr)
		else $error("tag parity check without interrupt");
	AST_DATA_FORCED: assert property (
		err_i.valid && err_i.kind == PCEL_K_DATAPAR && force_hit_reg
		|-> !cls.intr && !cls.mchk)
		else $error("data parity reported under forced hit");
	// level output tracks pending unmasked events one cycle late
	AST_IRQ_LEVEL: assert property (
		|(irq_sts_reg & irq_mask_reg) |=> irq_o)
		else $error("interrupt output not raised");
	AST_IRQ_LOW: assert property (
		!(|(irq_sts_reg & irq_mask_reg)) |=> !irq_o)
		else $error("interrupt output raised without cause");

	COV_SINGLE_TRAP: cover property (cls.mchk && !(|flags));
	COV_DOUBLE_TRAP: cover property (cls.mchk && first_reg);
	COV_TRAP_AFTER_INT: cover property (cls.mchk && int_flag_reg &&
	                                    !first_reg);
	COV_IRQ_READ: cover property (rd_irq && irq_o);
	COV_TAG_MCHK: cover property (cls.intr && cls.mchk);
endmodule

// ==== sim/pcel_core_model.sv ====
// core-side model that issues one-cycle error reports to the latch
`timescale 1ns/1ps
module pcel_core_model
	import pcel_pkg::*;
(
	// clock
	input  wire logic clk_i,
	// error report towards the latch
	output pcel_err_s err_o
);
	initial err_o = '0;

	// one report per call, then an idle cycle before the next may start
	task automatic send(input pcel_kind_e k, input pcel_cmd_e c,
	                    input logic lw2, input logic hit, input logic bc,
	                    input logic [31:0] a);
		@(posedge clk_i);
		err_o <= '{valid: 1'b1, kind: k, cmd: c, lw2: lw2, pc_hit: hit,
		           bc_hit: bc, addr: a};
		@(posedge clk_i);
		err_o <= '0;
	endtask
endmodule

// ==== sim/pcel_latch_tb_top.sv ====
// self-checking testbench for the primary cache error latch
`timescale 1ns/1ps
module pcel_latch_tb_top
	import pcel_pkg::*;
;
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [31:0] dat;
	logic [31:0] rd;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	pcel_err_s   err;
	logic [3:0]  idx;
	logic [31:0] tag_entry_o;
	logic        cache_enable_o;
	logic        flush_o;
	logic        refresh_enable_o;
	logic        forced_hit_o;
	logic        mchk_o;
	logic        irq_o;
	int          n_mismatch;
	int          tests_run;
	int          n_flush;

	pcel_latch #(.TAG_DEPTH(16)) u_pcel_latch (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .err_i(err),
		.tag_lkp_idx_i(idx), .tag_entry_o(tag_entry_o),
		.cache_enable_o(cache_enable_o), .flush_o(flush_o),
		.refresh_enable_o(refresh_enable_o),
		.forced_hit_o(forced_hit_o),
		.mchk_o(mchk_o), .irq_o(irq_o));

	pcel_core_model u_pcel_core_model (.clk_i(clk_i), .err_o(err));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [31:0] got,
	                   input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask

	// ack read right after an edge is the value that edge sampled
	task automatic wb(input logic w, input logic [7:0] a,
	                  input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			end_sim();
		end
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic mchk_pulses(output int n);
		n = 0;
		repeat (3) begin
			@(negedge clk_i);
			if (mchk_o === 1'b1) n++;
		end
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a,
	                      input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask

	// flags cleared, tag store on, pending interrupt bits cleared
	task automatic clean();
		wb(1'b1, OFF_STATUS, 32'h0000_0002);
		wb(1'b0, OFF_IRQSTS, 32'h0);
	endtask

	task automatic t_reset();
		rd_chk("status", OFF_STATUS, 32'h0);
		wb(1'b1, OFF_ERRADDR, 32'hffff_ffff);
		rd_chk("erraddr", OFF_ERRADDR, 32'h0);
		rd_chk("unmapped", 8'h20, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_tagpar();
		clean();
		u_pcel_core_model.send(PCEL_K_TAGPAR, PCEL_C_WRITE, 0, 0, 0, 32'h40);
		wait_n(3);
		chk("enable", {31'h0, cache_enable_o}, 32'h0);
		chk("irq masked", {31'h0, irq_o}, 32'h0);
		rd_chk("status", OFF_STATUS, 32'h0000_0122);
		wb(1'b1, OFF_IRQMASK, 32'h0000_0001);
		wait_n(3);
		chk("irq", {31'h0, irq_o}, 32'h1);
		rd_chk("irqsts", OFF_IRQSTS, 32'h0000_0001);
		wait_n(3);
		chk("irq clr", {31'h0, irq_o}, 32'h0);
		rd_chk("status held", OFF_STATUS, 32'h0000_0122);
		$display("test tag parity done");
	endtask

	task automatic t_int_then_mchk();
		int n;
		clean();
		u_pcel_core_model.send(PCEL_K_BUSPAR, PCEL_C_DREAD, 1, 0, 1, 32'h10);
		rd_chk("int lw2", OFF_STATUS, 32'h0000_1222);
		u_pcel_core_model.send(PCEL_K_BUSERR, PCEL_C_IREAD, 0, 0, 0, 32'h20);
		rd_chk("int kept", OFF_STATUS, 32'h0000_1222);
		u_pcel_core_model.send(PCEL_K_DATAPAR, PCEL_C_DREAD, 0, 1, 0,
		                       32'hdead_0004);
		mchk_pulses(n);
		chk("mchk pulse", n, 32'h1);
		rd_chk("mchk over int", OFF_STATUS, 32'h0000_04a2);
		rd_chk("erraddr", OFF_ERRADDR, 32'hdead_0004);
		u_pcel_core_model.send(PCEL_K_FPRES, PCEL_C_RESULT, 0, 0, 0,
		                       32'h1234_5678);
		mchk_pulses(n);
		chk("fp mchk", n, 32'h1);
		rd_chk("second", OFF_STATUS, 32'h0000_04e2);
		rd_chk("addr kept", OFF_ERRADDR, 32'hdead_0004);
		rd_chk("irq bits", OFF_IRQSTS, 32'h0000_0007);
		$display("test interrupt then machine check done");
	endtask

	task automatic t_refused();
		clean();
		u_pcel_core_model.send(PCEL_K_BUSERR, PCEL_C_EXTREG_RD, 0, 0, 0, 1);
		u_pcel_core_model.send(PCEL_K_BUSERR, PCEL_C_VECTOR_RD, 0, 0, 0, 2);
		rd_chk("no lock", OFF_STATUS, 32'h0000_0002);
		u_pcel_core_model.send(PCEL_K_DATAPAR, PCEL_C_DREAD, 0, 0, 0, 3);
		rd_chk("miss", OFF_STATUS, 32'h0000_0002);
		chk("enable", {31'h0, cache_enable_o}, 32'h1);
		rd_chk("erraddr", OFF_ERRADDR, 32'hdead_0004);
		$display("test refused reports done");
	endtask

	task automatic t_buspar_mchk();
		int n;
		clean();
		u_pcel_core_model.send(PCEL_K_BUSPAR, PCEL_C_DREAD, 0, 0, 0,
		                       32'h0000_abc0);
		mchk_pulses(n);
		chk("mchk pulse", n, 32'h1);
		rd_chk("lw1", OFF_STATUS, 32'h0000_0282);
		rd_chk("erraddr", OFF_ERRADDR, 32'h0000_abc0);
		chk("enable", {31'h0, cache_enable_o}, 32'h0);
		$display("test bus parity machine check done");
	endtask

	task automatic t_tag();
		clean();
		wb(1'b1, OFF_TAGIDX, 32'h3);
		wb(1'b1, OFF_TAGDATA, 32'hc123_4800);
		@(posedge clk_i);
		idx <= 4'h3;
		wait_n(3);
		chk("tag", tag_entry_o, 32'hc123_4800);
		rd_chk("no side effect", OFF_STATUS, 32'h0000_0002);
		$display("test tag write done");
	endtask

	task automatic t_more();
		int n;
		clean();
		u_pcel_core_model.send(PCEL_K_TAGPAR, PCEL_C_DREAD, 0, 1, 0, 32'h88);
		rd_chk("tag hit", OFF_STATUS, 32'h0000_01a2);
		rd_chk("tag addr", OFF_ERRADDR, 32'h0000_0088);
		clean();
		u_pcel_core_model.send(PCEL_K_DATAPAR, PCEL_C_IREAD, 0, 1, 0, 32'h90);
		rd_chk("iread data", OFF_STATUS, 32'h0000_0422);
		clean();
		u_pcel_core_model.send(PCEL_K_BUSERR, PCEL_C_CLRWB, 0, 0, 1,
		                       32'h300);
		rd_chk("clrwb", OFF_STATUS, 32'h0000_1882);
		rd_chk("clrwb addr", OFF_ERRADDR, 32'h0000_0300);
		n = n_flush;
		wb(1'b1, OFF_STATUS, 32'h0000_000f);
		wait_n(1);
		chk("flush", n_flush - n, 32'h1);
		rd_chk("modes", OFF_STATUS, 32'h0000_000b);
		chk("refresh", {31'h0, refresh_enable_o}, 32'h1);
		chk("forced", {31'h0, forced_hit_o}, 32'h1);
		u_pcel_core_model.send(PCEL_K_DATAPAR, PCEL_C_DREAD, 0, 1, 0, 4);
		u_pcel_core_model.send(PCEL_K_TAGPAR, PCEL_C_INVAL, 0, 1, 0, 5);
		rd_chk("forced quiet", OFF_STATUS, 32'h0000_000b);
		chk("enable", {31'h0, cache_enable_o}, 32'h1);
		clean();
		chk("refresh off", {31'h0, refresh_enable_o}, 32'h0);
		$display("test decoded commands and modes done");
	endtask

	// flush pulses seen by the core side
	always @(posedge clk_i) begin
		if (flush_o === 1'b1) begin
			n_flush <= n_flush + 1;
		end
	end

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// the whole sequence takes a few hundred cycles; this is far beyond
	initial begin
		#500000;
		n_mismatch++;
		end_sim();
	end

	initial begin
		n_mismatch = 0;
		tests_run = 0;
		n_flush = 0;
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		dat = 32'h0;
		idx = 4'h0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_tagpar();
		t_int_then_mchk();
		t_refused();
		t_buspar_mchk();
		t_tag();
		t_more();
		end_sim();
	end
endmodule
